// ===== fac_core.sv
// fault address capture unit with avalon register slave
// Contract
// - memory fault loads memory_fault_address with the faulting location
// - unaligned memory fault records the actual faulting address
// - split accesses may record any address within the requested size
// - memory_fault_address valid only while memory_fault_address_valid set
// - bus fault loads bus_fault_address with the faulting location
// - unaligned bus fault records the instruction's requested address
// - bus_fault_address valid only while bus_fault_address_valid set
// - fault address registers reachable only from privileged execution
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fac_core
    import fac_pkg::*;
#(
    parameter int AW = fac_pkg::ADDR_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_privileged,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic mem_fault,
    input wire logic [31:0] mem_fault_actual_addr,
    input wire logic bus_fault,
    input wire logic bus_fault_vector_read,
    input wire logic [31:0] bus_fault_requested_addr,
    output logic hard_fault_req,
    output logic irq
);
    import fac_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // fault capture state
    logic [31:0] mem_addr_reg, mem_addr_next;
    logic [31:0] bus_addr_reg, bus_addr_next;
    logic mem_valid_reg, mem_valid_next;
    logic bus_valid_reg, bus_valid_next;
    logic vect_reg, vect_next;
    logic hard_reg, hard_next;
    logic [NUM_EV-1:0] mask_reg, mask_next;
    logic [NUM_EV-1:0] ev_set, ev_clr, ev_bits;
    logic wr_take, rd_take, priv_ok;
    logic [31:0] wmask;

    fac_bus_e state_reg, state_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] resp_reg, resp_next;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end

    // write lands at the edge where waitrequest is seen low
    assign wr_take = (state_reg == FAC_RESP) && avs_write;
    assign rd_take = (state_reg == FAC_IDLE) && avs_read && !avs_write;
    assign priv_ok = avs_privileged;

    always_comb begin
        mem_addr_next = mem_addr_reg;
        bus_addr_next = bus_addr_reg;
        mem_valid_next = mem_valid_reg;
        bus_valid_next = bus_valid_reg;
        vect_next = vect_reg;
        hard_next = bus_fault && bus_fault_vector_read;
        mask_next = mask_reg;
        if (wr_take && priv_ok) begin
            case (avs_address)
                OFS_MEM_ADDR[AW-1:0]: begin
                    mem_addr_next = (mem_addr_reg & ~wmask) | (avs_writedata & wmask);
                end
                OFS_BUS_ADDR[AW-1:0]: begin
                    bus_addr_next = (bus_addr_reg & ~wmask) | (avs_writedata & wmask);
                end
                OFS_MEM_STAT[AW-1:0]: begin
                    if (avs_byteenable[0] && avs_writedata[BIT_MEM_VALID]) begin
                        mem_valid_next = 1'b0;
                    end
                end
                OFS_BUS_STAT[AW-1:0]: begin
                    if (avs_byteenable[0] && avs_writedata[BIT_BUS_VALID]) begin
                        bus_valid_next = 1'b0;
                    end
                end
                OFS_HARD_STAT[AW-1:0]: begin
                    if (avs_byteenable[0] && avs_writedata[BIT_VECT]) begin
                        vect_next = 1'b0;
                    end
                end
                OFS_IRQ_MASK[AW-1:0]: begin
                    if (avs_byteenable[0]) begin
                        mask_next = avs_writedata[NUM_EV-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (mem_fault) begin
            mem_addr_next = mem_fault_actual_addr;
            mem_valid_next = 1'b1;
        end
        if (bus_fault) begin
            bus_addr_next = bus_fault_requested_addr;
            bus_valid_next = 1'b1;
        end
        // vector read fault flag, set wins
        if (bus_fault && bus_fault_vector_read) begin
            vect_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_addr_reg <= RESET_WORD;
            bus_addr_reg <= RESET_WORD;
            mem_valid_reg <= 1'b0;
            bus_valid_reg <= 1'b0;
            vect_reg <= 1'b0;
            hard_reg <= 1'b0;
            mask_reg <= RESET_EV;
        end else begin
            mem_addr_reg <= mem_addr_next;
            bus_addr_reg <= bus_addr_next;
            mem_valid_reg <= mem_valid_next;
            bus_valid_reg <= bus_valid_next;
            vect_reg <= vect_next;
            hard_reg <= hard_next;
            mask_reg <= mask_next;
        end
    end

    // vector fault always escalates to hard fault
    assign hard_fault_req = hard_reg;

    ////////////////////////////////////////////////////////////////////
    // interrupt status
    assign ev_set[EV_MEM] = mem_fault;
    assign ev_set[EV_BUS] = bus_fault;
    assign ev_set[EV_VECT] = bus_fault && bus_fault_vector_read;
    assign ev_clr = (wr_take && priv_ok && avs_address == OFS_IRQ_STAT[AW-1:0]
        && avs_byteenable[0]) ? avs_writedata[NUM_EV-1:0] : '0;

    fac_event_bits #(
        .N(NUM_EV)
    ) u_events (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .bits_out(ev_bits)
    );

    assign irq = |(ev_bits & mask_reg);

    ////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer in the second
    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        resp_next = resp_reg;
        case (state_reg)
            FAC_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next = FAC_RESP;
                    resp_next = 2'h0;
                    rdata_next = DENY_WORD;
                    if (!priv_ok) begin
                        resp_next = 2'h2;
                    end else if (rd_take) begin
                        case (avs_address)
                            OFS_MEM_ADDR[AW-1:0]: rdata_next = mem_addr_reg;
                            OFS_BUS_ADDR[AW-1:0]: rdata_next = bus_addr_reg;
                            OFS_MEM_STAT[AW-1:0]: rdata_next = 32'(mem_valid_reg) << BIT_MEM_VALID;
                            OFS_BUS_STAT[AW-1:0]: rdata_next = 32'(bus_valid_reg) << BIT_BUS_VALID;
                            OFS_HARD_STAT[AW-1:0]: rdata_next = 32'(vect_reg) << BIT_VECT;
                            OFS_IRQ_STAT[AW-1:0]: rdata_next = 32'(ev_bits);
                            OFS_IRQ_MASK[AW-1:0]: rdata_next = 32'(mask_reg);
                            default: resp_next = 2'h3;
                        endcase
                    end
                end
            end
            FAC_RESP: begin
                state_next = FAC_DONE;
            end
            FAC_DONE: begin
                state_next = FAC_IDLE;
            end
            default: begin
                state_next = FAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= FAC_IDLE;
            rdata_reg <= RESET_WORD;
            resp_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
        end
    end

    assign avs_waitrequest = (state_reg != FAC_RESP);
    assign avs_readdata = rdata_reg;
    assign avs_response = resp_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_mem_capture: assert property (@(posedge sys_clk) disable iff (rst)
        mem_fault |=> (mem_addr_reg == $past(mem_fault_actual_addr)) && mem_valid_reg)
        else $error("memory fault address not captured");
    a_bus_capture: assert property (@(posedge sys_clk) disable iff (rst)
        bus_fault |=> (bus_addr_reg == $past(bus_fault_requested_addr)) && bus_valid_reg)
        else $error("bus fault address not captured");
    a_vect_hard: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_fault && bus_fault_vector_read) |=> vect_reg && hard_fault_req)
        else $error("vector read fault not flagged");
    a_unpriv_deny: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_IDLE && avs_read && !avs_privileged)
        |=> ##0 (avs_response == 2'h2 && avs_readdata == 32'h0000_0000))
        else $error("unprivileged access not refused");
    a_unpriv_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_RESP && avs_write && !avs_privileged && !mem_fault)
        |=> $stable(mem_addr_reg))
        else $error("unprivileged write changed an address");
    a_mem_valid: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(mem_valid_reg) |-> $past(mem_fault))
        else $error("memory valid set without fault");
    a_bus_valid: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(bus_valid_reg) |-> $past(bus_fault))
        else $error("bus valid set without fault");
    a_wait_one: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_IDLE && (avs_read || avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("slave answer not after one wait cycle");
    a_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
        (mask_reg == 3'h0) |-> !irq)
        else $error("interrupt high while all masked");

    // capture registers only move on a fault or a privileged write
    a_mem_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!mem_fault && !(wr_take && priv_ok && avs_address == OFS_MEM_ADDR[AW-1:0]))
        |=> $stable(mem_addr_reg))
        else $error("memory fault address moved without cause");
    a_bus_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!bus_fault && !(wr_take && priv_ok && avs_address == OFS_BUS_ADDR[AW-1:0]))
        |=> $stable(bus_addr_reg))
        else $error("bus fault address moved without cause");

    // valid and vector flags clear on a write of one
    a_mem_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take && priv_ok && avs_address == OFS_MEM_STAT[AW-1:0] && avs_byteenable[0]
        && avs_writedata[BIT_MEM_VALID] && !mem_fault) |=> !mem_valid_reg)
        else $error("memory valid not cleared by write of one");
    a_bus_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take && priv_ok && avs_address == OFS_BUS_STAT[AW-1:0] && avs_byteenable[0]
        && avs_writedata[BIT_BUS_VALID] && !bus_fault) |=> !bus_valid_reg)
        else $error("bus valid not cleared by write of one");
    a_vect_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take && priv_ok && avs_address == OFS_HARD_STAT[AW-1:0] && avs_byteenable[0]
        && avs_writedata[BIT_VECT] && !(bus_fault && bus_fault_vector_read)) |=> !vect_reg)
        else $error("vector flag not cleared by write of one");
    a_vect_source: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(vect_reg) |-> $past(bus_fault && bus_fault_vector_read))
        else $error("vector flag set without vector read fault");
    a_hard_source: assert property (@(posedge sys_clk) disable iff (rst)
        hard_fault_req |-> $past(bus_fault && bus_fault_vector_read))
        else $error("hard fault request without vector read fault");

    // refused writes and bus answer timing
    a_unpriv_bus: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_RESP && avs_write && !avs_privileged && !bus_fault)
        |=> $stable(bus_addr_reg))
        else $error("unprivileged write changed the bus fault address");
    a_unpriv_mask: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_RESP && avs_write && !avs_privileged) |=> $stable(mask_reg))
        else $error("unprivileged write changed the mask");
    a_read_stands: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_DONE) |-> $stable(avs_readdata) && $stable(avs_response))
        else $error("answer did not stand after the answer cycle");
    a_done_wait: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == FAC_DONE) |-> avs_waitrequest)
        else $error("waitrequest low in the idle gap");
    a_state_onehot: assert property (@(posedge sys_clk) disable iff (rst)
        $onehot(state_reg))
        else $error("bus state not one-hot");

    // interrupt mask and event path
    a_mask_write: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_take && priv_ok && avs_address == OFS_IRQ_MASK[AW-1:0] && avs_byteenable[0])
        |=> mask_reg == $past(avs_writedata[NUM_EV-1:0]))
        else $error("mask write not taken");
    a_irq_event: assert property (@(posedge sys_clk) disable iff (rst)
        (mem_fault && mask_reg[EV_MEM] && !wr_take) |=> irq)
        else $error("unmasked memory fault raised no interrupt");
endmodule
`default_nettype wire

// ===== fac_pkg.sv
// constants and types for the fault address capture block
package fac_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_MEM_ADDR = 12'hd34;
    localparam logic [11:0] OFS_BUS_ADDR = 12'hd38;
    localparam logic [11:0] OFS_MEM_STAT = 12'hd40;
    localparam logic [11:0] OFS_BUS_STAT = 12'hd44;
    localparam logic [11:0] OFS_HARD_STAT = 12'hd48;
    localparam logic [11:0] OFS_IRQ_STAT = 12'hd50;
    localparam logic [11:0] OFS_IRQ_MASK = 12'hd54;
    localparam int BIT_MEM_VALID = 7;
    localparam int BIT_BUS_VALID = 7;
    localparam int BIT_VECT = 1;
    localparam int EV_MEM = 0;
    localparam int EV_BUS = 1;
    localparam int EV_VECT = 2;
    localparam int NUM_EV = 3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] DENY_WORD = 32'h0000_0000;
    localparam logic [2:0] RESET_EV = 3'h0;
    typedef enum logic [2:0] {
        FAC_IDLE = 3'b001,
        FAC_RESP = 3'b010,
        FAC_DONE = 3'b100
    } fac_bus_e;
endpackage

// ===== fac_event_bits.sv
// sticky event bits with write-one-to-clear, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module fac_event_bits #(
    parameter int N = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] set_in,
    input wire logic [N-1:0] clr_in,
    output logic [N-1:0] bits_out
);
    logic [N-1:0] bits_reg;
    logic [N-1:0] bits_next;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_comb begin
                bits_next[g] = set_in[g] | (bits_reg[g] & ~clr_in[g]);
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bits_reg <= '0;
        end else begin
            bits_reg <= bits_next;
        end
    end

    assign bits_out = bits_reg;

    a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        (set_in != '0) |=> ((bits_out & $past(set_in)) == $past(set_in)))
        else $error("event bit lost while set and clear coincide");
endmodule
`default_nettype wire

// ===== fac_fault_src.sv
// load/store and exception side model that raises fault pulses
`timescale 1ns/1ns
`default_nettype none
module fac_fault_src (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] split_ofs,
    output logic mem_fault,
    output logic [31:0] mem_fault_actual_addr,
    output logic bus_fault,
    output logic bus_fault_vector_read,
    output logic [31:0] bus_fault_requested_addr
);
    always_ff @(posedge sys_clk) begin
        mem_fault <= 1'b0;
        bus_fault <= 1'b0;
        bus_fault_vector_read <= 1'b0;
        // released address lines do not hold their last value
        mem_fault_actual_addr <= ~mem_fault_actual_addr;
        bus_fault_requested_addr <= ~bus_fault_requested_addr;
        if (rst) begin
            mem_fault_actual_addr <= 32'h0;
            bus_fault_requested_addr <= 32'h0;
        end else if (go) begin
            mem_fault <= (kind == 2'h0);
            mem_fault_actual_addr <= req_addr + {30'h0, split_ofs};
            bus_fault <= (kind != 2'h0);
            bus_fault_vector_read <= (kind == 2'h2);
            bus_fault_requested_addr <= req_addr;
        end
    end
endmodule
`default_nettype wire

// ===== tb_fault_address_capture.sv
// self-checking bench for the fault address capture unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_fault_address_capture;
    import fac_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic avs_privileged = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [31:0] req_addr = 32'h0;
    logic [1:0] split_ofs = 2'h0;
    logic mem_fault, bus_fault, bus_fault_vector_read, hard_fault_req, irq;
    logic [31:0] mem_fault_actual_addr, bus_fault_requested_addr, a, seed = 32'h1;
    logic [2:0] mask = 3'h0;
    int miscompares = 0;
    int num_checks = 0;
    int hf_cnt = 0;
    always #25 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (hard_fault_req === 1'b1) hf_cnt++;
    fac_fault_src u_fac_fault_src (.sys_clk(sys_clk), .rst(rst), .go(go), .kind(kind),
        .req_addr(req_addr), .split_ofs(split_ofs), .mem_fault(mem_fault),
        .mem_fault_actual_addr(mem_fault_actual_addr), .bus_fault(bus_fault),
        .bus_fault_vector_read(bus_fault_vector_read),
        .bus_fault_requested_addr(bus_fault_requested_addr));
    fac_core u_fac_core (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_privileged(avs_privileged),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .mem_fault(mem_fault), .mem_fault_actual_addr(mem_fault_actual_addr),
        .bus_fault(bus_fault), .bus_fault_vector_read(bus_fault_vector_read),
        .bus_fault_requested_addr(bus_fault_requested_addr),
        .hard_fault_req(hard_fault_req), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d,
        input logic p, output logic [31:0] q, output logic [1:0] r);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_privileged <= p;
        // request held until waitrequest is seen low at a rising edge
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // one edge between transfers, no double assignment
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic p);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, ad, d, p, q, r);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [1:0] er,
        input logic p);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, ad, 32'h0, p, q, r);
        `CHK(q, e)
        `CHK(r, er)
    endtask
    task automatic fault(input logic [1:0] k, input logic [1:0] o);
        go <= 1'b1;
        kind <= k;
        req_addr <= a;
        split_ofs <= o;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic irq_chk(input logic [2:0] e);
        rd(OFS_IRQ_STAT, {29'h0, e}, 2'h0, 1'b1);
        repeat (2) @(negedge sys_clk);
        `CHK(irq, |(e & mask))
        @(posedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #150000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_MEM_STAT, 32'h0, 2'h0, 1'b1);
        rd(OFS_BUS_STAT, 32'h0, 2'h0, 1'b1);
        rd(OFS_HARD_STAT, 32'h0, 2'h0, 1'b1);
        mask = 3'h7;
        wr(OFS_IRQ_MASK, 32'h7, 1'b1);
        for (int i = 0; i < 3; i++) begin
            a = xs();
            fault(2'h0, a[5:4]);
            rd(OFS_MEM_ADDR, a + {30'h0, a[5:4]}, 2'h0, 1'b1);
            rd(OFS_MEM_STAT, 32'h80, 2'h0, 1'b1);
            irq_chk(3'h1);
            wr(OFS_MEM_STAT, 32'h80, 1'b1);
            rd(OFS_MEM_STAT, 32'h0, 2'h0, 1'b1);
            mask = (i == 1) ? 3'h6 : 3'h7;
            wr(OFS_IRQ_MASK, {29'h0, mask}, 1'b1);
            irq_chk(3'h1);
            wr(OFS_IRQ_STAT, 32'h1, 1'b1);
            irq_chk(3'h0);
            a = xs();
            fault(2'h1, 2'h0);
            rd(OFS_BUS_ADDR, a, 2'h0, 1'b1);
            rd(OFS_BUS_STAT, 32'h80, 2'h0, 1'b1);
            irq_chk(3'h2);
            wr(OFS_BUS_STAT, 32'h80, 1'b1);
            wr(OFS_IRQ_STAT, 32'h2, 1'b1);
            rd(OFS_BUS_STAT, 32'h0, 2'h0, 1'b1);
        end
        `CHK(hf_cnt, 0)
        $display("test capture done");
        wr(OFS_BUS_ADDR, xs(), 1'b0);
        rd(OFS_BUS_ADDR, 32'h0, 2'h2, 1'b0);
        rd(OFS_BUS_ADDR, a, 2'h0, 1'b1);
        a = xs();
        wr(OFS_MEM_ADDR, a, 1'b1);
        rd(OFS_MEM_ADDR, a, 2'h0, 1'b1);
        // low byte lane only
        avs_byteenable <= 4'h1;
        wr(OFS_MEM_ADDR, ~a, 1'b1);
        avs_byteenable <= 4'hf;
        rd(OFS_MEM_ADDR, {a[31:8], ~a[7:0]}, 2'h0, 1'b1);
        rd(12'h100, 32'h0, 2'h3, 1'b1);
        $display("test privilege done");
        fault(2'h2, 2'h0);
        `CHK(hf_cnt, 1)
        rd(OFS_HARD_STAT, 32'h2, 2'h0, 1'b1);
        wr(OFS_HARD_STAT, 32'h2, 1'b1);
        rd(OFS_HARD_STAT, 32'h0, 2'h0, 1'b1);
        $display("test vector done");
        complete_run();
    end
endmodule
`default_nettype wire
